// ===== verilog/rtc_sup.sv
// rtc supervisor: oscillator stop, bus-stuck timeout, power gating, sqw
// Notes on behaviour
// - The stop flag sets once the oscillator halts, within 100 ms.
// - A serial clock held low beyond 25 ms within one period is recognised.
// - After 35 ms of low clock the slave resets, frees data, awaits START.
// - The timeout reset only happens while the oscillator runs.
// - Power-up holds off host access 1 ms, only with a running oscillator.
// - Backup present and main supply below threshold block host access.
// - Timekeeping ticks carry on from either supply.
// - One open-drain pin carries a square wave or an active-low interrupt.
// - The data line is only pulled low; the pull-up gives the high level.
// - The device is an I2C slave entered by START; STOP is not detected.
`timescale 1ns/1ps
`include "rtc_sup_defines.svh"
module rtc_sup #(
  parameter int STOP_CYC = `RTC_STOP_CYC,
  parameter int REC_CYC = `RTC_REC_CYC,
  parameter int DEAD_CYC = `RTC_DEAD_CYC,
  parameter int CW = 22
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic osc_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic below_power_fail_threshold,
  input wire logic backup_supply,
  input wire logic slv_sda_low,
  input wire logic osc_stop_clr,
  input wire logic sqw_mode,
  input wire rtc_pkg::rtc_sqw_rate_e sqw_rate,
  input wire logic irq_n,
  output logic square_wave_irq_out,
  output logic square_wave_irq_out_oe,
  output logic osc_stop_flag,
  output logic osc_running,
  output logic bus_stuck,
  output logic slave_reset,
  output logic i2c_start,
  output logic host_access_ok,
  output logic sec_tick
);
  import rtc_pkg::*;

  // ************************************************************
  // oscillator domain
  // ************************************************************
  logic scl_o1_q, scl_o2_q, alive_tgl_q, tmo_tgl_q, stuck_q, sqw_q;
  logic [`RTC_TMO_W-1:0] tmo_cnt_q;
  logic [`RTC_DIV_W-1:0] div_q;
  logic [1:0] rate_o1_q, rate_o2_q; // quasi-static, two flops suffice

  always_ff @(posedge osc_clk or negedge rstn) begin
    if (!rstn) begin
      scl_o1_q <= 1'b1;
      scl_o2_q <= 1'b1;
      {rate_o1_q, rate_o2_q} <= 4'h0;
    end else begin
      scl_o1_q <= scl_in;
      scl_o2_q <= scl_o1_q;
      {rate_o1_q, rate_o2_q} <= {sqw_rate, rate_o1_q};
    end
  end
  // free-running divider keeps time on either supply
  always_ff @(posedge osc_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
      alive_tgl_q <= 1'b0;
    end else begin
      div_q <= div_q + `RTC_DIV_W'(1);
      alive_tgl_q <= ~alive_tgl_q;
    end
  end
  // counting on the oscillator means a stopped oscillator never times out
  always_ff @(posedge osc_clk or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt_q <= '0;
      tmo_tgl_q <= 1'b0;
      stuck_q <= 1'b0;
    end else begin
      if (scl_o2_q) begin
        tmo_cnt_q <= '0;
        stuck_q <= 1'b0;
      end else begin
        if (tmo_cnt_q != `RTC_TMO_W'(`RTC_TMO_CYC)) begin
          tmo_cnt_q <= tmo_cnt_q + `RTC_TMO_W'(1);
        end
        if (tmo_cnt_q >= `RTC_TMO_W'(`RTC_TMO_MIN_CYC)) begin
          stuck_q <= 1'b1;
        end
        if (tmo_cnt_q == `RTC_TMO_W'(`RTC_TMO_CYC - 1)) begin
          tmo_tgl_q <= ~tmo_tgl_q;
        end
      end
    end
  end

  always_ff @(posedge osc_clk or negedge rstn) begin
    if (!rstn) begin
      sqw_q <= 1'b0;
    end else begin
      unique case (rtc_sqw_rate_e'(rate_o2_q))
        RTC_SQW_1HZ: sqw_q <= div_q[`RTC_SEC_TAP];
        RTC_SQW_4KHZ: sqw_q <= div_q[`RTC_TAP_4K];
        RTC_SQW_8KHZ: sqw_q <= div_q[`RTC_TAP_8K];
        RTC_SQW_16KHZ: sqw_q <= div_q[`RTC_TAP_16K];
      endcase
    end
  end

  // ************************************************************
  // synchronisers into the system clock
  // ************************************************************
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic pf_s1_q, pf_s2_q, bk_s1_q, bk_s2_q;
  logic alv_s1_q, alv_s2_q, alv_s3_q, tmo_s1_q, tmo_s2_q, tmo_s3_q;
  logic stk_s1_q, stk_s2_q, sqw_s1_q, sqw_s2_q;
  logic sec_s1_q, sec_s2_q, sec_s3_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {pf_s1_q, pf_s2_q, bk_s1_q, bk_s2_q} <= 4'h0;
      {alv_s1_q, alv_s2_q, alv_s3_q} <= 3'h0;
      {tmo_s1_q, tmo_s2_q, tmo_s3_q} <= 3'h0;
      {stk_s1_q, stk_s2_q, sqw_s1_q, sqw_s2_q} <= 4'h0;
      {sec_s1_q, sec_s2_q, sec_s3_q} <= 3'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
      {pf_s1_q, pf_s2_q} <= {below_power_fail_threshold, pf_s1_q};
      {bk_s1_q, bk_s2_q} <= {backup_supply, bk_s1_q};
      {alv_s1_q, alv_s2_q, alv_s3_q} <= {alive_tgl_q, alv_s1_q, alv_s2_q};
      {tmo_s1_q, tmo_s2_q, tmo_s3_q} <= {tmo_tgl_q, tmo_s1_q, tmo_s2_q};
      {stk_s1_q, stk_s2_q} <= {stuck_q, stk_s1_q};
      {sqw_s1_q, sqw_s2_q} <= {sqw_q, sqw_s1_q};
      {sec_s1_q, sec_s2_q, sec_s3_q} <=
        {div_q[`RTC_SEC_TAP], sec_s1_q, sec_s2_q};
    end
  end

  logic osc_edge, tmo_evt, start_evt, pf_blk, osc_alive, stop_set;
  logic [CW-1:0] stop_cnt_q;
  assign osc_edge = alv_s2_q ^ alv_s3_q;
  assign tmo_evt = tmo_s2_q ^ tmo_s3_q;
  assign start_evt = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign pf_blk = pf_s2_q & bk_s2_q;
  assign osc_alive = stop_cnt_q < CW'(DEAD_CYC);
  assign stop_set = ~osc_edge & (stop_cnt_q == CW'(STOP_CYC - 1));

  // ************************************************************
  // oscillator watch
  // ************************************************************
  logic osc_stop_q, osc_run_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stop_cnt_q <= '0;
    end else if (osc_edge) begin
      stop_cnt_q <= '0;
    end else if (stop_cnt_q != CW'(STOP_CYC - 1)) begin
      stop_cnt_q <= stop_cnt_q + CW'(1);
    end
  end

  // a stop event in the clearing cycle still leaves the flag set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_stop_q <= 1'b0;
      osc_run_q <= 1'b0;
    end else begin
      osc_run_q <= osc_alive;
      if (stop_set) begin
        osc_stop_q <= 1'b1;
      end else if (osc_stop_clr) begin
        osc_stop_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // bus timeout and START
  // ************************************************************
  logic slv_rst_q, start_q, stuck_out_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slv_rst_q <= 1'b0;
      start_q <= 1'b0;
      stuck_out_q <= 1'b0;
    end else begin
      start_q <= start_evt;
      stuck_out_q <= stk_s2_q & osc_alive;
      if (tmo_evt && osc_alive) begin
        slv_rst_q <= 1'b1;
      end else if (start_evt) begin
        slv_rst_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // power-up recovery and power-fail gating
  // ************************************************************
  logic rec_busy_q, host_ok_q;
  logic [CW-1:0] rec_cnt_q;
  // a dead oscillator ends the wait as soon as its absence is seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rec_busy_q <= 1'b1;
      rec_cnt_q <= '0;
    end else if (pf_blk) begin
      rec_busy_q <= 1'b1;
      rec_cnt_q <= '0;
    end else if (rec_busy_q) begin
      if (!osc_alive || rec_cnt_q == CW'(REC_CYC - 1)) begin
        rec_busy_q <= 1'b0;
      end else begin
        rec_cnt_q <= rec_cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      host_ok_q <= 1'b0;
    end else begin
      host_ok_q <= ~rec_busy_q & ~pf_blk & ~slv_rst_q;
    end
  end

  // ************************************************************
  // open-drain pins and tick
  // ************************************************************
  logic sda_oe_q, sqw_oe_q, sec_q, od_lvl_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sda_oe_q <= 1'b0;
      sqw_oe_q <= 1'b0;
      sec_q <= 1'b0;
      od_lvl_q <= 1'b0;
    end else begin
      od_lvl_q <= 1'b0;
      sda_oe_q <= slv_sda_low & host_ok_q;
      sqw_oe_q <= sqw_mode ? ~sqw_s2_q : ~irq_n;
      sec_q <= sec_s2_q & ~sec_s3_q;
    end
  end

  assign sda_out = od_lvl_q;
  assign sda_oe = sda_oe_q;
  assign square_wave_irq_out = od_lvl_q;
  assign square_wave_irq_out_oe = sqw_oe_q;
  assign osc_stop_flag = osc_stop_q;
  assign osc_running = osc_run_q;
  assign bus_stuck = stuck_out_q;
  assign slave_reset = slv_rst_q;
  assign i2c_start = start_q;
  assign host_access_ok = host_ok_q;
  assign sec_tick = sec_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_blocked;
    pf_blk ##1 1'b1;
  endsequence
  a_stop_set: assert property (@(posedge clock) disable iff (!rstn)
    stop_set |=> osc_stop_q) else $error("stop flag not set");
  a_stop_hold: assert property (@(posedge clock) disable iff (!rstn)
    osc_stop_q && !osc_stop_clr |=> osc_stop_q) else $error("stop flag lost");
  a_stuck_min: assert property (@(posedge osc_clk) disable iff (!rstn)
    !scl_o2_q && tmo_cnt_q == `RTC_TMO_W'(`RTC_TMO_MIN_CYC) |=> stuck_q)
    else $error("stuck not seen");
  a_tmo_reset: assert property (@(posedge clock) disable iff (!rstn)
    tmo_evt && osc_alive |=> slv_rst_q ##1 !host_ok_q ##1 !sda_oe_q)
    else $error("timeout did not free bus");
  a_tmo_gated: assert property (@(posedge clock) disable iff (!rstn)
    tmo_evt && !osc_alive && !slv_rst_q |=> !slv_rst_q)
    else $error("timeout with stopped oscillator");
  a_rec_hold: assert property (@(posedge clock) disable iff (!rstn)
    rec_busy_q && osc_alive && !pf_blk && rec_cnt_q < CW'(REC_CYC - 1)
    |=> rec_busy_q ##0 !host_ok_q) else $error("recovery cut short");
  a_pf_block: assert property (@(posedge clock) disable iff (!rstn)
    s_blocked |-> !host_ok_q ##1 !sda_oe_q)
    else $error("access while power failed");
  a_sqw_irq: assert property (@(posedge clock) disable iff (!rstn)
    !sqw_mode |=> sqw_oe_q == !$past(irq_n)) else $error("irq not shown");
  a_sda_drive: assert property (@(posedge clock) disable iff (!rstn)
    sda_oe_q |-> $past(slv_sda_low) && !sda_out) else $error("bad sda drive");
  a_start_free: assert property (@(posedge clock) disable iff (!rstn)
    start_evt && !tmo_evt |=> !slv_rst_q ##0 start_q)
    else $error("start did not release");
  a_tmo_restart: assert property (@(posedge osc_clk) disable iff (!rstn)
    scl_o2_q |=> tmo_cnt_q == '0) else $error("counter not restarted");
endmodule

// ===== verilog/rtc_sup_defines.svh
// timing constants and tap positions of the rtc supervisory block
`ifndef RTC_SUP_DEFINES_SVH
`define RTC_SUP_DEFINES_SVH

// ************************************************************
// clock rates
// ************************************************************
`define RTC_CLK_HZ 25000000
`define RTC_OSC_HZ 32768

// ************************************************************
// times as printed
// ************************************************************
`define RTC_STOP_MS 100
`define RTC_TMO_MIN_MS 25
`define RTC_TMO_MAX_MS 35
`define RTC_REC_TYP_US 1000
`define RTC_DEAD_US 100
// oscillator edges lost between scl falling and the first counted sample
`define RTC_SYNC_LAT 3

// ************************************************************
// derived cycle counts
// ************************************************************
`define RTC_STOP_CYC (`RTC_STOP_MS * (`RTC_CLK_HZ / 1000))
`define RTC_REC_CYC (`RTC_REC_TYP_US * (`RTC_CLK_HZ / 1000000))
`define RTC_DEAD_CYC (`RTC_DEAD_US * (`RTC_CLK_HZ / 1000000))
`define RTC_TMO_MIN_CYC ((`RTC_TMO_MIN_MS * `RTC_OSC_HZ + 999) / 1000)
`define RTC_TMO_CYC ((`RTC_TMO_MAX_MS * `RTC_OSC_HZ) / 1000 - `RTC_SYNC_LAT)

// ************************************************************
// widths and divider taps
// ************************************************************
`define RTC_TMO_W 11
`define RTC_DIV_W 15
`define RTC_SEC_TAP 14
`define RTC_TAP_4K 2
`define RTC_TAP_8K 1
`define RTC_TAP_16K 0

`endif

// ===== verilog/rtc_pkg.sv
// types shared by the rtc supervisory block
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_SQW_1HZ = 2'h0,
    RTC_SQW_4KHZ = 2'h1,
    RTC_SQW_8KHZ = 2'h2,
    RTC_SQW_16KHZ = 2'h3
  } rtc_sqw_rate_e;
endpackage

// ===== bench/rtc_i2c_master.sv
// i2c master model facing the rtc supervisor bus pins
`timescale 1ns/1ps
module rtc_i2c_master (
  input wire logic clock,
  input wire logic sda_oe,
  input wire logic scl_hold,
  output logic scl,
  output logic sda
);
  logic sda_low;
  initial sda_low = 1'b0;
  // open-drain wires with pull-ups: low while any party pulls
  assign scl = !scl_hold;
  assign sda = !(sda_low | sda_oe);
  // start then stop, each edge well apart so the slave syncs it
  task automatic start_stop();
    @(posedge clock);
    #2 sda_low = 1'b1;
    repeat (8) @(posedge clock);
    #2 sda_low = 1'b0;
  endtask
endmodule

// ===== bench/rtc_sup_tb_top.sv
// self-checking bench of the rtc supervisor
`timescale 1ns/1ps
module rtc_sup_tb_top;
  import rtc_pkg::*;
  localparam int REC = 50;
  localparam int STOP = 200;
  logic clock, rstn, osc_clk, osc_en, scl, sda, scl_hold;
  logic sda_out, sda_oe, below, backup, slv, stop_clr, sqw_mode, irq_n;
  rtc_sqw_rate_e sqw_rate;
  logic sq_out, sq_oe, stop_flag, osc_run, stuck, srst, start, ok, tick, p;
  int n_fail, num_checks, seed, r, t;

  rtc_sup #(.STOP_CYC(STOP), .REC_CYC(REC), .DEAD_CYC(20)) uut (
    .clock(clock), .rstn(rstn), .osc_clk(osc_clk), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .below_power_fail_threshold(below), .backup_supply(backup),
    .slv_sda_low(slv), .osc_stop_clr(stop_clr), .sqw_mode(sqw_mode),
    .sqw_rate(sqw_rate), .irq_n(irq_n), .square_wave_irq_out(sq_out),
    .square_wave_irq_out_oe(sq_oe), .osc_stop_flag(stop_flag),
    .osc_running(osc_run), .bus_stuck(stuck), .slave_reset(srst),
    .i2c_start(start), .host_access_ok(ok), .sec_tick(tick));
  rtc_i2c_master m (.clock(clock), .sda_oe(sda_oe), .scl_hold(scl_hold),
    .scl(scl), .sda(sda));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // oscillator stands still while disabled, as a halted crystal would
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #24 if (osc_en) osc_clk = ~osc_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic sig(int i);
    case (i)
      0: return ok;
      1: return stuck;
      2: return srst;
      3: return stop_flag;
      4: return sda_oe;
      5: return start;
      default: return tick;
    endcase
  endfunction
  function automatic logic sqw_ok(int k, int n);
    return (k == 0) ? (n <= 1) : (n >= 2);
  endfunction
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %0h seen %0h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wait_on(int i, logic v, int lim, string n);
    int k;
    k = 0;
    while (sig(i) !== v && k < lim) begin
      step(1);
      k++;
    end
    chk(n, v, sig(i));
    if (sig(i) !== v) final_report();
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    final_report();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 32'h9456;
    n_fail = 0;
    num_checks = 0;
    {rstn, below, backup, slv, stop_clr, sqw_mode, scl_hold} = 7'h00;
    osc_en = 1'b1;
    irq_n = 1'b1;
    sqw_rate = RTC_SQW_1HZ;
    step(6);
    chk("access_in_reset", 0, ok);
    rstn = 1'b1;
    step(REC - 5);
    chk("access_early", 0, ok);
    wait_on(0, 1, 20, "access_up");
    chk("osc_run", 1, osc_run);
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      irq_n = r[0];
      step(2);
      chk("irq_oe", !irq_n, sq_oe);
      chk("irq_pin", 0, sq_out);
    end
    sqw_mode = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sqw_rate = rtc_sqw_rate_e'(k);
      step(8);
      t = 0;
      p = sq_oe;
      repeat (64) begin
        step(1);
        if (sq_oe !== p) t++;
        p = sq_oe;
      end
      chk("sqw_toggles", 1, sqw_ok(k, t));
    end
    slv = 1'b1;
    wait_on(4, 1, 5, "sda_drive");
    chk("sda_out", 0, sda_out);
    chk("sda_wire", 0, sda);
    below = 1'b1;
    step(10);
    chk("no_backup_ok", 1, ok);
    backup = 1'b1;
    wait_on(0, 0, 6, "pf_block");
    wait_on(4, 0, 3, "pf_sda");
    wait_on(6, 1, 39400, "tick_on_backup");
    below = 1'b0;
    step(REC - 5);
    chk("pf_early", 0, ok);
    wait_on(0, 1, 20, "pf_recover");
    scl_hold = 1'b1;
    step(840);
    chk("short_low", 0, stuck);
    scl_hold = 1'b0;
    step(10);
    scl_hold = 1'b1;
    step(980);
    chk("stuck_early", 0, stuck);
    wait_on(1, 1, 30, "stuck_seen");
    step(340);
    chk("reset_early", 0, srst);
    wait_on(2, 1, 80, "tmo_reset");
    wait_on(4, 0, 4, "tmo_release");
    scl_hold = 1'b0;
    step(10);
    fork
      m.start_stop();
      wait_on(5, 1, 20, "start_seen");
    join
    chk("reset_cleared", 0, srst);
    wait_on(4, 1, 5, "sda_again");
    osc_en = 1'b0;
    step(STOP - 10);
    chk("stop_early", 0, stop_flag);
    wait_on(3, 1, 20, "stop_set");
    chk("osc_dead", 0, osc_run);
    stop_clr = 1'b1;
    step(1);
    stop_clr = 1'b0;
    step(2);
    chk("stop_held", 1, stop_flag);
    scl_hold = 1'b1;
    step(1500);
    chk("no_tmo_dead_osc", 0, srst);
    scl_hold = 1'b0;
    osc_en = 1'b1;
    step(30);
    stop_clr = 1'b1;
    step(1);
    stop_clr = 1'b0;
    wait_on(3, 0, 3, "stop_clear");
    osc_en = 1'b0;
    rstn = 1'b0;
    step(2);
    chk("access_in_reset2", 0, ok);
    rstn = 1'b1;
    wait_on(0, 1, 35, "rec_dead_osc");
    chk("osc_dead_rst", 0, osc_run);
    final_report();
  end
endmodule
